// file: hdl/ras_pkg.sv
// package for the return address stack: map, fields, vectors, types
package ras_pkg;

    localparam int ADDR_W          = 21;
    localparam int PTR_W           = 5;
    localparam int DEPTH           = 31;

    // byte offsets on the register bus
    localparam logic [7:0] OFF_STACK_POINTER_STATUS = 8'h00;
    localparam logic [7:0] OFF_TOP_U  = 8'h04;
    localparam logic [7:0] OFF_TOP_H  = 8'h08;
    localparam logic [7:0] OFF_TOP_L  = 8'h0C;
    localparam logic [7:0] OFF_CONFIG = 8'h10;
    localparam logic [7:0] OFF_FAST   = 8'h14;

    // stack pointer status fields
    localparam int FULL_BIT        = 7;
    localparam int UNDER_BIT       = 6;
    localparam int PTR_LSB         = 0;

    // config register: bit 0 overflow reset enable
    localparam int ORE_BIT         = 0;
    localparam logic ORE_RESET     = 1'b1;

    localparam logic [20:0] RESET_VECTOR   = 21'h000000;
    localparam logic [20:0] VEC_HIGH       = 21'h000008;
    localparam logic [20:0] VEC_LOW        = 21'h000018;
    localparam logic [20:0] PC_STEP        = 21'h000002;
    localparam logic [4:0]  PTR_EMPTY      = 5'h00;
    localparam logic [4:0]  PTR_TOP        = 5'h1F;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        RAS_OP_NONE,
        RAS_OP_CALL,
        RAS_OP_PUSH,
        RAS_OP_RETURN,
        RAS_OP_POP
    } ras_op_e;

    // core request: one operation per cycle
    typedef struct packed {
        ras_op_e     op;
        logic        fast;
        logic        irq;
        logic        irq_high;
        logic [20:0] pc;
    } ras_req_s;

    // working registers covered by the shadow
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] working_register;
        logic [7:0] bank_select_register;
    } ras_ctx_s;

endpackage : ras_pkg

// file: hdl/ras_shadow.sv
// one-deep shadow of status, working and bank-select registers
module ras_shadow
    import ras_pkg::*;
(
    // clock and reset
    input  wire logic     clock,
    input  wire logic     reset,
    // capture side
    input  wire logic     load,
    input  wire ras_ctx_s ctx_in,
    // restore side
    output ras_ctx_s      ctx_out
);

    ras_ctx_s shadow_reg;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            shadow_reg <= '0;
        else if (load)
            shadow_reg <= ctx_in;
    end

    assign ctx_out = shadow_reg;

    a_shadow_load: assert property (@(posedge clock) disable iff (reset)
        load |=> ctx_out == $past(ctx_in)) else $error("shadow did not capture");

endmodule : ras_shadow

// file: hdl/ras_stack.sv
// return address stack with axi4-lite access to pointer and top entry
//
// Summary of operation
// - fetches above implemented memory but inside 2-Mbyte space return zero.
// - execution starts at 0000h; interrupts vector to 0008h or 0018h.
// - stack is 31 words of 21 bits with 5-bit pointer.
// - calls and interrupt acknowledge push pc; returns pop pc.
// - every reset clears pointer; pointer zero has no storage word.
// - push increments pointer, then writes pc to the new entry.
// - pop copies the selected entry to pc, then decrements pointer.
// - upper, high, low top registers read and write the selected entry.
// - software reads and writes the pointer field, range 0 to 31.
// - full flag sets after 31 pushes without a pop.
// - full and underflow flags clear only by software or power-on reset.
// - overflow reset enabled: 31st push stores pc+2, sets full, resets device.
// - overflow reset disabled: pointer goes to 31, later pushes change nothing.
// - pop at pointer zero returns zero, sets underflow, pointer stays zero.
// - underflow sets the flag, then resets device when enabled.
// - status register: full bit 7, underflow bit 6, bit 5 zero, pointer 4:0.
// - explicit push increments pointer and stores pc, flow unchanged.
// - explicit pop only decrements pointer; at pointer zero it sets underflow instead.
// - one-deep shadow captures status, working, bank-select on interrupt vector.
// - fast return restores status, working and bank-select from shadow.
// - interrupts of both priorities load the shadow, high overwrites low.
// - fast call also loads the shadow.
module ras_stack
    import ras_pkg::*;
#(
    parameter int          DEPTH_P   = DEPTH,
    parameter logic [20:0] MEM_LIMIT = 21'h008000
)
(
    // clock and resets
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              por,
    // core side
    input  wire ras_req_s          req,
    input  wire ras_ctx_s          ctx_now,
    output logic [20:0]            pc_load,
    output logic                   pc_load_valid,
    output logic                   ctx_restore,
    output ras_ctx_s               ctx_saved,
    output logic                   device_reset_req,
    // program memory fetch gate
    input  wire logic [20:0]       fetch_addr,
    input  wire logic [15:0]       fetch_raw,
    output logic [15:0]            fetch_data,
    // axi4-lite slave
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////
    // storage and state

    logic [20:0] stack_mem [1:DEPTH_P];
    logic [4:0]  ptr_reg;
    logic        full_reg;
    logic        under_reg;
    logic        ore_reg;

    ////////////////////////////////////////////////////////////////////////////
    // fetch gate and vectors

    assign fetch_data = (fetch_addr >= MEM_LIMIT) ? 16'h0000 : fetch_raw;

    ////////////////////////////////////////////////////////////////////////////
    // core operation decode

    wire is_push   = (req.op == RAS_OP_CALL) || (req.op == RAS_OP_PUSH) || req.irq;
    // an acknowledged interrupt overrides whatever op the core shows
    wire is_pop    = !req.irq && ((req.op == RAS_OP_RETURN) || (req.op == RAS_OP_POP));
    wire ptr_zero  = (ptr_reg == PTR_EMPTY);
    wire ptr_max   = (ptr_reg == PTR_TOP);
    wire [4:0] ptr_inc = ptr_reg + 5'h01;
    // thirtieth entry in use means this push is the 31st
    wire push_last = is_push && (ptr_inc == PTR_TOP);
    wire push_ok   = is_push && !ptr_max;
    wire pop_under = is_pop && ptr_zero;
    // overflow reset stores the return past the call
    wire [20:0] push_val = (push_last && ore_reg) ? 21'(req.pc + PC_STEP) : req.pc;
    wire [20:0] top_word = ptr_zero ? 21'h000000 : stack_mem[ptr_reg];

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    logic        aw_held_reg;
    logic [7:0]  aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire        aw_take  = s_axi_awvalid && s_axi_awready;
    wire        w_take   = s_axi_wvalid && s_axi_wready;
    wire        aw_have  = aw_held_reg || aw_take;
    wire        w_have   = w_held_reg || w_take;
    wire [7:0]  wr_addr  = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wire [31:0] wr_data  = w_held_reg ? w_data_reg : s_axi_wdata;
    wire        wr_lane0 = w_held_reg ? w_strb_reg[0] : s_axi_wstrb[0];
    wire        wr_fire  = aw_have && w_have;
    wire        wr_en    = wr_fire && wr_lane0;
    wire [7:0]  wb       = wr_data[7:0];

    wire wr_sp  = wr_en && (wr_addr == OFF_STACK_POINTER_STATUS);
    wire wr_tu  = wr_en && (wr_addr == OFF_TOP_U);
    wire wr_th  = wr_en && (wr_addr == OFF_TOP_H);
    wire wr_tl  = wr_en && (wr_addr == OFF_TOP_L);
    wire wr_cfg = wr_en && (wr_addr == OFF_CONFIG);
    wire wr_map = (wr_addr == OFF_STACK_POINTER_STATUS) || (wr_addr == OFF_TOP_U) || (wr_addr == OFF_TOP_H)
               || (wr_addr == OFF_TOP_L) || (wr_addr == OFF_CONFIG);

    // status layout, bit 5 reads zero
    wire [7:0] sp_read = {full_reg, under_reg, 1'b0, ptr_reg};

    // top registers view the selected entry
    logic [31:0] rd_mux;
    logic        rd_map;
    always_comb
    begin
        rd_map = 1'b1;
        case (s_axi_araddr)
            OFF_STACK_POINTER_STATUS: rd_mux = {24'h000000, sp_read};
            OFF_TOP_U:  rd_mux = {27'h0000000, top_word[20:16]};
            OFF_TOP_H:  rd_mux = {24'h000000, top_word[15:8]};
            OFF_TOP_L:  rd_mux = {24'h000000, top_word[7:0]};
            OFF_CONFIG: rd_mux = {31'h00000000, ore_reg};
            default:
            begin
                rd_mux = 32'h00000000;
                rd_map = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            aw_held_reg  <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_held_reg   <= 1'b0;
            w_data_reg   <= 32'h00000000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else
        begin
            if (wr_fire)
            begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end
            else
            begin
                if (aw_take)
                begin
                    aw_held_reg <= 1'b1;
                    aw_addr_reg <= s_axi_awaddr;
                end
                if (w_take)
                begin
                    w_held_reg <= 1'b1;
                    w_data_reg <= s_axi_wdata;
                    w_strb_reg <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointer and flags

    // flags survive any reset but power-on, so they sit on por
    always_ff @(posedge clock or posedge por)
    begin
        if (por)
        begin
            full_reg  <= 1'b0;
            under_reg <= 1'b0;
            ore_reg   <= ORE_RESET;
        end
        else
        begin
            if (wr_cfg)
                ore_reg <= wb[ORE_BIT];
            // set wins over a software clear in the same cycle
            if (push_last)
                full_reg <= 1'b1;
            else if (wr_sp && !wb[FULL_BIT])
                full_reg <= 1'b0;
            if (pop_under)
                under_reg <= 1'b1;
            else if (wr_sp && !wb[UNDER_BIT])
                under_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            ptr_reg <= PTR_EMPTY;
        else if (push_ok)
            // increment, saturate at 31 when not resetting
            ptr_reg <= ptr_inc;
        else if (is_pop && !ptr_zero)
            ptr_reg <= ptr_reg - 5'h01;
        else if (wr_sp && !is_push && !is_pop)
            // software sets pointer; a core push or pop in the same cycle wins
            ptr_reg <= wb[4:0];
    end

    // write pushed pc into the new entry; no entry at zero
    genvar gi;
    generate
        for (gi = 1; gi <= DEPTH_P; gi++)
        begin : g_entry
            wire push_here = push_ok && (ptr_inc == 5'(gi));
            wire top_here  = (ptr_reg == 5'(gi)) && !is_push;
            always_ff @(posedge clock)
            begin
                if (push_here)
                    stack_mem[gi] <= push_val;
                else if (top_here && wr_tu)
                    stack_mem[gi][20:16] <= wb[4:0];
                else if (top_here && wr_th)
                    stack_mem[gi][15:8] <= wb;
                else if (top_here && wr_tl)
                    stack_mem[gi][7:0] <= wb;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // return, reset request and shadow

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pc_load          <= RESET_VECTOR;
            pc_load_valid    <= 1'b1;
            ctx_restore      <= 1'b0;
            device_reset_req <= 1'b0;
        end
        else
        begin
            pc_load_valid    <= 1'b0;
            ctx_restore      <= 1'b0;
            // flag is set on the same edge that the reset is requested
            device_reset_req <= ore_reg && (push_last || pop_under);
            if (req.irq)
            begin
                pc_load       <= req.irq_high ? VEC_HIGH : VEC_LOW;
                pc_load_valid <= 1'b1;
            end
            else if (req.op == RAS_OP_RETURN)
            begin
                // pop to pc, zero on underflow
                pc_load       <= top_word;
                pc_load_valid <= 1'b1;
                ctx_restore   <= req.fast;
            end
        end
    end

    // shadow loads on any vector and on fast call
    ras_shadow u_shadow (
        .clock   (clock),
        .reset   (reset),
        .load    (req.irq || (req.op == RAS_OP_CALL && req.fast)),
        .ctx_in  (ctx_now),
        .ctx_out (ctx_saved)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_push_ptr_inc: assert property (@(posedge clock) disable iff (reset)
        push_ok |=> ptr_reg == $past(ptr_reg) + 5'h01) else $error("push did not increment");
    a_push_stores: assert property (@(posedge clock) disable iff (reset)
        push_ok && !push_last |=> top_word == $past(req.pc)) else $error("push value wrong");
    a_pop_returns: assert property (@(posedge clock) disable iff (reset)
        req.op == RAS_OP_RETURN && !req.irq |=> pc_load_valid && pc_load == $past(top_word))
        else $error("return value wrong");
    a_under_flag: assert property (@(posedge clock) disable iff (reset || por)
        pop_under |=> under_reg && ptr_reg == PTR_EMPTY) else $error("underflow not flagged");
    a_full_flag: assert property (@(posedge clock) disable iff (reset || por)
        push_last |=> full_reg) else $error("full not flagged");
    a_full_sat: assert property (@(posedge clock) disable iff (reset)
        ptr_max && is_push |=> ptr_reg == PTR_TOP) else $error("pointer passed 31");
    a_ovf_reset: assert property (@(posedge clock) disable iff (reset)
        ore_reg && (push_last || pop_under) |=> device_reset_req) else $error("no stack reset");
    a_zero_top: assert property (@(posedge clock) disable iff (reset)
        s_axi_arvalid && s_axi_arready && ptr_zero
        && (s_axi_araddr == OFF_TOP_U || s_axi_araddr == OFF_TOP_H || s_axi_araddr == OFF_TOP_L)
        |=> s_axi_rdata == 32'h00000000) else $error("top not zero at empty");
    a_irq_vector: assert property (@(posedge clock) disable iff (reset)
        req.irq |=> pc_load_valid && pc_load == ($past(req.irq_high) ? VEC_HIGH : VEC_LOW))
        else $error("bad vector");
    a_fast_ret: assert property (@(posedge clock) disable iff (reset)
        req.op == RAS_OP_RETURN && req.fast && !req.irq |=> ctx_restore) else $error("no restore");

    c_full: cover property (@(posedge clock) push_last);
    c_under: cover property (@(posedge clock) pop_under);
    c_fast: cover property (@(posedge clock) req.op == RAS_OP_RETURN && req.fast);
    c_tos_wr: cover property (@(posedge clock) wr_tl && !ptr_zero);

endmodule : ras_stack

// file: testbench/ras_core_model.sv
// core-side model: issues one stack request and collects the registered answer
module ras_core_model
    import ras_pkg::*;
(
    // clock
    input  wire logic        clock,
    // requests to the stack
    output ras_req_s         req,
    output ras_ctx_s         ctx_now,
    // answers from the stack
    input  wire logic [20:0] pc_load,
    input  wire logic        pc_load_valid,
    input  wire logic        ctx_restore,
    input  wire ras_ctx_s    ctx_saved,
    input  wire logic        device_reset_req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        req     = '0;
        ctx_now = '0;
    end

    // the answer stands one cycle only, so it is sampled at the edge after the taking edge
    task automatic issue(input ras_req_s r, input ras_ctx_s c, output logic [47:0] ans);
        @(posedge clock);
        req     <= r;
        ctx_now <= c;
        @(posedge clock);
        req     <= '0;
        @(posedge clock);
        ans = {pc_load, pc_load_valid, ctx_restore, ctx_saved, device_reset_req};
    endtask : issue
endmodule : ras_core_model

// file: testbench/return_address_stack_tb.sv
// self-checking bench of the return address stack against a queue-free integer model
module return_address_stack_tb;
    import ras_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [20:0] MEM_LIM = 21'h008000;
    logic clock = 1'b0, reset = 1'b1, por = 1'b1;
    ras_req_s req;
    ras_ctx_s ctx_now, ctx_saved;
    logic [20:0] pc_load, fetch_addr = '0;
    logic pc_load_valid, ctx_restore, device_reset_req;
    logic [15:0] fetch_raw = '0, fetch_data;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_errors = 0, n_compared = 0, seed = 20457, k, m_ptr;
    logic [20:0] m_mem [32];
    logic m_full, m_unf, m_ore, m_shv;
    ras_ctx_s m_ctx;

    always #5 clock = ~clock;

    ras_stack #(.MEM_LIMIT(MEM_LIM)) i_ras_stack (.clock(clock), .reset(reset), .por(por), .req(req),
        .ctx_now(ctx_now), .pc_load(pc_load), .pc_load_valid(pc_load_valid), .ctx_restore(ctx_restore),
        .ctx_saved(ctx_saved), .device_reset_req(device_reset_req), .fetch_addr(fetch_addr),
        .fetch_raw(fetch_raw), .fetch_data(fetch_data), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    ras_core_model i_ras_core_model (.clock(clock), .req(req), .ctx_now(ctx_now), .pc_load(pc_load),
        .pc_load_valid(pc_load_valid), .ctx_restore(ctx_restore), .ctx_saved(ctx_saved),
        .device_reset_req(device_reset_req));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic give_up(input int n);
        if (n >= 50)
        begin
            chk("bus wait", 0, 1);
            summarize();
        end
    endtask : give_up

    // both channels offered together; each released at its own ready edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_p, w_p;
        int   n;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clock);
            if (!aw_p && !w_p && s_axi_bvalid)
                break;
            aw_p = aw_p && !s_axi_awready;
            w_p = w_p && !s_axi_wready;
            s_axi_awvalid <= aw_p;
            s_axi_wvalid <= w_p;
        end
        give_up(n);
        chk("bresp", 32'(er), 32'(s_axi_bresp));
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ar_p;
        int   n;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        ar_p = 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clock);
            if (!ar_p && s_axi_rvalid)
                break;
            ar_p = ar_p && !s_axi_arready;
            s_axi_arvalid <= ar_p;
        end
        give_up(n);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        chk("rdata", e, s_axi_rdata);
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic chk_sp();
        rd(OFF_STACK_POINTER_STATUS, {24'h0, m_full, m_unf, 1'b0, 5'(m_ptr)}, RESP_OKAY);
    endtask : chk_sp

    // pointer zero has no word behind it, so the top reads zero there
    task automatic chk_top();
        logic [20:0] e;
        e = (m_ptr > 0) ? m_mem[m_ptr] : 21'h0;
        rd(OFF_TOP_U, {27'h0, e[20:16]}, RESP_OKAY);
        rd(OFF_TOP_H, {24'h0, e[15:8]}, RESP_OKAY);
        rd(OFF_TOP_L, {24'h0, e[7:0]}, RESP_OKAY);
    endtask : chk_top

    task automatic sys_reset(input logic p);
        @(posedge clock);
        reset <= 1'b1;
        por <= p;
        repeat (4) @(posedge clock);
        chk("pc_load_valid", 1, 32'(pc_load_valid));
        chk("pc_load", 32'(RESET_VECTOR), 32'(pc_load));
        reset <= 1'b0;
        por <= 1'b0;
        m_ptr = 0;
        m_shv = 0;
        m_full = p ? 1'b0 : m_full;
        m_unf = p ? 1'b0 : m_unf;
        m_ore = p ? 1'b1 : m_ore;
    endtask : sys_reset

    ////////////////////////////////////////////////////////////////////////////////
    task automatic do_op(input ras_op_e o, input logic f, input logic ir, input logic hi);
        logic [47:0] ans;
        logic [20:0] pc, val;
        ras_ctx_s    cx;
        logic        push, pop, ev, er, ed;
        pc = 21'($random(seed)) & 21'h1FFFFE;
        cx = 24'($random(seed));
        push = ir || o == RAS_OP_CALL || o == RAS_OP_PUSH;
        pop = !ir && (o == RAS_OP_RETURN || o == RAS_OP_POP);
        ev = ir || (o == RAS_OP_RETURN);
        er = !ir && o == RAS_OP_RETURN && f;
        val = ir ? (hi ? VEC_HIGH : VEC_LOW) : 21'h0;
        ed = pop && m_ptr == 0 && m_ore;
        m_unf = m_unf || (pop && m_ptr == 0);
        if (ir || (o == RAS_OP_CALL && f))
        begin
            m_ctx = cx;
            m_shv = 1'b1;
        end
        if (push && m_ptr < 31)
        begin
            m_ptr++;
            m_mem[m_ptr] = (m_ptr == 31 && m_ore) ? pc + PC_STEP : pc;
            m_full = m_full || m_ptr == 31;
            ed = m_ptr == 31 && m_ore;
        end
        if (pop && m_ptr > 0)
        begin
            val = ir ? val : m_mem[m_ptr];
            m_ptr--;
        end
        i_ras_core_model.issue('{o, f, ir, hi, pc}, cx, ans);
        chk("pc_load_valid", 32'(ev), 32'(ans[26]));
        if (ev)
            chk("pc_load", 32'(val), 32'(ans[47:27]));
        chk("ctx_restore", 32'(er), 32'(ans[25]));
        if (m_shv)
            chk("ctx_saved", 32'(m_ctx), 32'(ans[24:1]));
        chk("device_reset_req", 32'(ed), 32'(ans[0]));
    endtask : do_op

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_reset(1'b1);
        chk_sp();
        rd(OFF_CONFIG, 32'(ORE_RESET), RESP_OKAY);
        wr(OFF_CONFIG, 32'h0, RESP_OKAY);
        m_ore = 1'b0;
        for (k = 0; k < 32; k++)
            do_op((k % 3 == 0) ? RAS_OP_PUSH : RAS_OP_CALL, k == 4, 1'b0, 1'b0);
        chk_sp();
        chk_top();
        do_op(RAS_OP_NONE, 1'b0, 1'b1, 1'b0);
        do_op(RAS_OP_NONE, 1'b0, 1'b1, 1'b1);
        do_op(RAS_OP_RETURN, 1'b1, 1'b0, 1'b0);
        wr(OFF_TOP_L, 32'h0000005A, RESP_OKAY);
        m_mem[m_ptr][7:0] = 8'h5A;
        chk_top();
        do_op(RAS_OP_POP, 1'b0, 1'b0, 1'b0);
        chk_sp();
        for (k = 0; k < 32 && m_ptr > 0; k++)
            do_op(RAS_OP_RETURN, k[0], 1'b0, 1'b0);
        do_op(RAS_OP_RETURN, 1'b0, 1'b0, 1'b0);
        chk_sp();
        wr(OFF_TOP_L, 32'h000000A5, RESP_OKAY);
        chk_top();
        wr(OFF_STACK_POINTER_STATUS, 32'h000000E5, RESP_OKAY);
        m_ptr = 5;
        chk_sp();
        sys_reset(1'b0);
        chk_sp();
        wr(OFF_STACK_POINTER_STATUS, 32'h0, RESP_OKAY);
        m_full = 1'b0;
        m_unf = 1'b0;
        chk_sp();
        wr(OFF_CONFIG, 32'h1, RESP_OKAY);
        m_ore = 1'b1;
        wr(OFF_STACK_POINTER_STATUS, 32'h0000001E, RESP_OKAY);
        m_ptr = 30;
        do_op(RAS_OP_CALL, 1'b0, 1'b0, 1'b0);
        chk_top();
        sys_reset(1'b0);
        chk_sp();
        do_op(RAS_OP_RETURN, 1'b0, 1'b0, 1'b0);
        sys_reset(1'b0);
        chk_sp();
        sys_reset(1'b1);
        chk_sp();
        rd(OFF_CONFIG, 32'(ORE_RESET), RESP_OKAY);
        rd(OFF_FAST, 32'h0, RESP_SLVERR);
        wr(OFF_FAST, 32'h1, RESP_SLVERR);
        for (k = 0; k < 16; k++)
        begin
            @(posedge clock);
            fetch_addr <= (k < 2) ? MEM_LIM - 21'h2 + 21'(2 * k) : 21'($random(seed));
            fetch_raw <= 16'($random(seed));
            @(posedge clock);
            chk("fetch_data", (fetch_addr >= MEM_LIM) ? 32'h0 : 32'(fetch_raw), 32'(fetch_data));
        end
        summarize();
    end
endmodule : return_address_stack_tb
